// >>> src/dcdm_pkg.sv
// constants shared by the disk command decode and sector map block
package dcdm_pkg;

    // ==========================================================
    // command opcodes
    localparam logic [7:0] OP_TEST_READY    = 8'h00;
    localparam logic [7:0] OP_RECALIBRATE   = 8'h01;
    localparam logic [7:0] OP_SENSE_STATUS  = 8'h03;
    localparam logic [7:0] OP_FORMAT_DRIVE  = 8'h04;
    localparam logic [7:0] OP_CHECK_FORMAT  = 8'h05;
    localparam logic [7:0] OP_FORMAT_TRACK  = 8'h06;
    localparam logic [7:0] OP_FORMAT_BAD    = 8'h07;
    localparam logic [7:0] OP_READ_DATA     = 8'h08;
    localparam logic [7:0] OP_READ_NO_XFER  = 8'h09;
    localparam logic [7:0] OP_WRITE_DATA    = 8'h0A;
    localparam logic [7:0] OP_SEEK          = 8'h0B;
    localparam logic [7:0] OP_INIT_CHAR     = 8'h0C;
    localparam logic [7:0] OP_ECC_LENGTH    = 8'h0D;
    localparam logic [7:0] OP_FORMAT_ALT    = 8'h0E;
    localparam logic [7:0] OP_WRITE_BUFFER  = 8'h0F;
    localparam logic [7:0] OP_READ_BUFFER   = 8'h10;
    localparam logic [7:0] OP_CTRL_TYPE     = 8'h11;
    localparam logic [7:0] OP_READ_ID_PHYS  = 8'h12;
    localparam logic [7:0] OP_READ_ID_LOG   = 8'h13;
    localparam logic [7:0] OP_CHECK_ECC     = 8'h14;

    typedef enum logic [2:0] {GRP_CONTROLLER, GRP_DISK, GRP_BUFFER, GRP_TRACK, GRP_RWS, GRP_INVALID} dcdm_group_e;

    // ==========================================================
    // command string and status layout
    localparam int         CMD_BYTES        = 6;
    localparam int         CMD_IL_BYTE      = 4;
    localparam int         ST_UNIT_LSB      = 5;
    localparam int         ST_WP_BIT        = 3;
    localparam int         ST_ERR_BIT       = 1;
    localparam int         MSG_VALID_BIT    = 7;
    localparam logic [1:0] UNIT_TAPE        = 2'h2;
    localparam logic [6:0] ERR_NOT_READY    = 7'h04;
    localparam logic [6:0] ERR_INVALID_CMD  = 7'h20;
    localparam logic [6:0] ERR_BAD_IL       = 7'h21;

    // ==========================================================
    // defect map sector layout
    localparam logic [7:0] MAP_HASH_FIRST   = 8'h03;
    localparam logic [7:0] MAP_COUNT_BYTE   = 8'h03;
    localparam logic [7:0] MAP_FIRST_ENTRY  = 8'h04;
    localparam logic [7:0] MAP_LAST_BYTE    = 8'hFF;
    localparam logic [7:0] MAP_MAX_ENTRIES  = 8'h3F;
    localparam int         FLAG_WHOLE_BIT   = 0;
    localparam int         FLAG_DIAG_BIT    = 1;
    localparam int         FLAG_OS_BIT      = 2;
    localparam logic [23:0] HASH_INIT       = 24'h000000;
    localparam int         MAP_FIFO_DEPTH   = 16;

endpackage : dcdm_pkg

// >>> src/dcdm_fifo.sv
// synchronous valid/ready fifo for the interleave map stream
`timescale 1ns/1ps
module dcdm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("dcdm_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = ce_i && in_valid_i && in_ready_o;
    assign pop         = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end

endmodule : dcdm_fifo

// >>> src/dcdm_hash.sv
// 24-bit rolling hash over the defect map sector bytes
`timescale 1ns/1ps
module dcdm_hash (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // byte stream
    input  wire logic        clear_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    // result
    output logic      [23:0] hash_o
);
    // rotate-and-xor: cheap, and every byte position affects the result
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hash_o <= dcdm_pkg::HASH_INIT;
        end else if (ce_i) begin
            if (clear_i) begin
                hash_o <= dcdm_pkg::HASH_INIT;
            end else if (byte_valid_i) begin
                hash_o <= {hash_o[22:0], hash_o[23]} ^ {16'h0000, byte_i};
            end
        end
    end

endmodule : dcdm_hash

// >>> src/dcdm_top.sv
// disk command decode, interleave map, address math and defect map check
//
// How it works
// - opcodes 00, 03, 0C, 11 decode to the controller group.
// - opcodes 01, 04 entire disk; 05, 06, 07, 0E track and format group.
// - 08, 09, 0A, 0B decode to the read, write and seek group.
// - 0D, 12, 13, 14 read/write group; 0F and 10 buffer group.
// - format maps logical n to physical (n * interleave) mod sectors, stepping to the next free slot on a common factor.
// - read buffer not drained by next logical sector forces a revolution wait.
// - logical address is ((cylinder * heads) + head) * sectors + sector.
// - next to last cylinder holds the defect map and its copies.
// - defects on the map cylinder ignored; failed map read moves to copy track.
// - map sector holds four byte header and at most 63 entries.
// - header bytes 0..2 hash least significant first, byte 3 entry count.
// - hash covers sector bytes 3 through 255.
// - entry bytes 0..2 track most significant first, byte 3 error flag.
// - linear track is cylinder * heads plus head.
// - flag bit 0 whole track, bit 1 diagnostic, bit 2 operating system.
// - drive-ready test checks the selected unit and reports in status.
// - all drive status correct clears error flag, message 00.
// - any drive status wrong sets error flag, message holds error code.
// - status byte has unit in bits 6..5, write protect 3, error 1.
`timescale 1ns/1ps
module dcdm_top (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // command bytes from host
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_byte_i,
    output logic             cmd_ready_o,
    // completion
    output logic             done_o,
    output logic [7:0]       status_byte_o,
    output logic [7:0]       message_byte_o,
    output dcdm_pkg::dcdm_group_e group_o,
    output logic [7:0]       opcode_o,
    // drive geometry
    input  wire logic [15:0] cylinders_i,
    input  wire logic [7:0]  heads_per_cylinder_i,
    input  wire logic [7:0]  sectors_per_track_i,
    // drive pins
    input  wire logic [2:0]  unit_ready_i,
    input  wire logic [1:0]  write_protect_i,
    input  wire logic        sector_mark_i,
    // address math
    input  wire logic [15:0] cylinder_index_i,
    input  wire logic [7:0]  head_index_i,
    input  wire logic [7:0]  sector_index_i,
    output logic [31:0]      logical_addr_o,
    output logic [23:0]      linear_track_o,
    output logic             on_map_cylinder_o,
    // interleave map stream
    output logic             map_valid_o,
    output logic [7:0]       map_logical_o,
    output logic [7:0]       map_physical_o,
    input  wire logic        map_ready_i,
    // read pacing
    input  wire logic        buf_loaded_i,
    input  wire logic        host_drained_i,
    output logic             rev_wait_o,
    // defect map sector
    input  wire logic        dm_start_i,
    input  wire logic        dm_valid_i,
    input  wire logic [7:0]  dm_byte_i,
    input  wire logic        dm_read_fail_i,
    output logic             dm_done_o,
    output logic             dm_ok_o,
    output logic             defect_hit_o,
    output logic [2:0]       defect_flags_o,
    output logic [7:0]       copy_head_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_COLLECT, ST_EXEC, ST_MAP, ST_DONE} dcdm_state_e;

    dcdm_state_e state;
    logic [7:0]  cmd [dcdm_pkg::CMD_BYTES];
    logic [2:0]  cmd_idx;
    logic [2:0]  ready_s1, ready_s2;
    logic [1:0]  wp_s1, wp_s2;
    logic        mark_s1, mark_s2, mark_s3;
    logic        mark_rise;
    logic [1:0]  unit;
    dcdm_pkg::dcdm_group_e next_group;
    logic        is_format;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ready_s1 <= 3'h0;
            ready_s2 <= 3'h0;
            wp_s1    <= 2'h0;
            wp_s2    <= 2'h0;
            mark_s1  <= 1'b0;
            mark_s2  <= 1'b0;
            mark_s3  <= 1'b0;
        end else if (ce_i) begin
            ready_s1 <= unit_ready_i;
            ready_s2 <= ready_s1;
            wp_s1    <= write_protect_i;
            wp_s2    <= wp_s1;
            mark_s1  <= sector_mark_i;
            mark_s2  <= mark_s1;
            mark_s3  <= mark_s2;
        end
    end
    assign mark_rise = mark_s2 && !mark_s3;

    // ==========================================================
    // opcode decode
    always_comb begin
        case (cmd[0])
            dcdm_pkg::OP_TEST_READY, dcdm_pkg::OP_SENSE_STATUS,
            dcdm_pkg::OP_INIT_CHAR, dcdm_pkg::OP_CTRL_TYPE:     next_group = dcdm_pkg::GRP_CONTROLLER;
            dcdm_pkg::OP_FORMAT_DRIVE, dcdm_pkg::OP_RECALIBRATE: next_group = dcdm_pkg::GRP_DISK;
            dcdm_pkg::OP_CHECK_FORMAT, dcdm_pkg::OP_FORMAT_TRACK,
            dcdm_pkg::OP_FORMAT_BAD, dcdm_pkg::OP_FORMAT_ALT:    next_group = dcdm_pkg::GRP_TRACK;
            dcdm_pkg::OP_WRITE_BUFFER, dcdm_pkg::OP_READ_BUFFER: next_group = dcdm_pkg::GRP_BUFFER;
            dcdm_pkg::OP_READ_DATA, dcdm_pkg::OP_READ_NO_XFER,
            dcdm_pkg::OP_WRITE_DATA, dcdm_pkg::OP_SEEK:          next_group = dcdm_pkg::GRP_RWS;
            dcdm_pkg::OP_ECC_LENGTH, dcdm_pkg::OP_READ_ID_PHYS,
            dcdm_pkg::OP_READ_ID_LOG, dcdm_pkg::OP_CHECK_ECC:    next_group = dcdm_pkg::GRP_RWS;
            default:                                             next_group = dcdm_pkg::GRP_INVALID;
        endcase
    end

    assign unit      = cmd[1][6:5];
    assign is_format = (cmd[0] == dcdm_pkg::OP_FORMAT_DRIVE) || (cmd[0] == dcdm_pkg::OP_FORMAT_TRACK)
                    || (cmd[0] == dcdm_pkg::OP_FORMAT_BAD) || (cmd[0] == dcdm_pkg::OP_FORMAT_ALT);

    // ==========================================================
    // interleave generator
    logic [7:0] il;
    logic [7:0] gen_n;
    logic [7:0] gen_pos;
    logic [7:0] gen_cycle;
    logic [8:0] sum;
    logic [7:0] next_pos;
    logic       gen_push;
    logic       gen_last;
    logic       fifo_in_ready;
    logic [15:0] fifo_out;

    assign il       = cmd[dcdm_pkg::CMD_IL_BYTE];
    assign sum      = {1'b0, gen_pos} + {1'b0, il};
    assign gen_push = (state == ST_MAP) && fifo_in_ready;
    assign gen_last = (gen_n == sectors_per_track_i - 8'h01);

    // wrap modulo sectors; on a common factor, step to the next free slot
    always_comb begin
        next_pos = (sum >= {1'b0, sectors_per_track_i}) ? 8'(sum - {1'b0, sectors_per_track_i}) : sum[7:0];
        if (next_pos == gen_cycle) begin
            next_pos = gen_cycle + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            gen_n     <= 8'h00;
            gen_pos   <= 8'h00;
            gen_cycle <= 8'h00;
        end else if (ce_i) begin
            if (state != ST_MAP) begin
                gen_n     <= 8'h00;
                gen_pos   <= 8'h00;
                gen_cycle <= 8'h00;
            end else if (gen_push) begin
                gen_n   <= gen_n + 8'h01;
                gen_pos <= next_pos;
                if (next_pos == gen_cycle + 8'h01) begin
                    gen_cycle <= next_pos;
                end
            end
        end
    end

    dcdm_fifo #(
        .WIDTH (16),
        .DEPTH (dcdm_pkg::MAP_FIFO_DEPTH)
    ) u_map_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_valid_i  (gen_push),
        .in_data_i   ({gen_n, gen_pos}),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (map_valid_o),
        .out_data_o  (fifo_out),
        .out_ready_i (map_ready_i)
    );
    assign map_logical_o  = fifo_out[15:8];
    assign map_physical_o = fifo_out[7:0];

    // ==========================================================
    // command sequencer and completion status
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state          <= ST_IDLE;
            cmd_idx        <= 3'h0;
            done_o         <= 1'b0;
            status_byte_o  <= 8'h00;
            message_byte_o <= 8'h00;
            group_o        <= dcdm_pkg::GRP_INVALID;
            opcode_o       <= 8'h00;
            for (int i = 0; i < dcdm_pkg::CMD_BYTES; i++) cmd[i] <= 8'h00;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state)
                ST_IDLE, ST_COLLECT: begin
                    if (cmd_valid_i) begin
                        cmd[cmd_idx] <= cmd_byte_i;
                        state        <= ST_COLLECT;
                        if (cmd_idx == 3'(dcdm_pkg::CMD_BYTES - 1)) begin
                            cmd_idx <= 3'h0;
                            state   <= ST_EXEC;
                        end else begin
                            cmd_idx <= cmd_idx + 3'h1;
                        end
                    end
                end
                ST_EXEC: begin
                    group_o       <= next_group;
                    opcode_o      <= cmd[0];
                    status_byte_o <= 8'h00;
                    status_byte_o[dcdm_pkg::ST_UNIT_LSB +: 2] <= unit;
                    status_byte_o[dcdm_pkg::ST_WP_BIT] <= (unit != dcdm_pkg::UNIT_TAPE) && wp_s2[unit[0]];
                    message_byte_o <= 8'h00;
                    state          <= ST_DONE;
                    if (next_group == dcdm_pkg::GRP_INVALID) begin
                        status_byte_o[dcdm_pkg::ST_ERR_BIT] <= 1'b1;
                        message_byte_o <= {1'b1, dcdm_pkg::ERR_INVALID_CMD};
                    end else if (cmd[0] == dcdm_pkg::OP_TEST_READY && (unit == 2'h3 || !ready_s2[unit])) begin
                        status_byte_o[dcdm_pkg::ST_ERR_BIT] <= 1'b1;
                        message_byte_o <= {1'b1, dcdm_pkg::ERR_NOT_READY};
                    end else if (is_format && (il >= sectors_per_track_i)) begin
                        // out-of-range factor would never land every sector
                        status_byte_o[dcdm_pkg::ST_ERR_BIT] <= 1'b1;
                        message_byte_o <= {1'b1, dcdm_pkg::ERR_BAD_IL};
                    end else if (is_format) begin
                        state <= ST_MAP;
                    end
                end
                ST_MAP: begin
                    if (gen_push && gen_last) begin
                        state <= ST_DONE;
                    end
                end
                default: begin
                    done_o <= 1'b1;
                    state  <= ST_IDLE;
                end
            endcase
        end
    end
    assign cmd_ready_o = (state == ST_IDLE) || (state == ST_COLLECT);

    // ==========================================================
    // address math
    logic [23:0] lin_track;
    logic [15:0] map_cyl;
    assign lin_track = 24'({8'h00, cylinder_index_i} * {16'h0000, heads_per_cylinder_i})
        + {16'h0000, head_index_i};
    assign map_cyl   = cylinders_i - 16'h0002;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            logical_addr_o    <= 32'h00000000;
            linear_track_o    <= 24'h000000;
            on_map_cylinder_o <= 1'b0;
        end else if (ce_i) begin
            logical_addr_o    <= 32'({8'h00, lin_track} * {24'h000000, sectors_per_track_i})
                + {24'h000000, sector_index_i};
            linear_track_o    <= lin_track;
            on_map_cylinder_o <= (cylinder_index_i == map_cyl);
        end
    end

    // ==========================================================
    // read pacing: next logical sector is il marks after the load
    logic       pace_busy;
    logic [8:0] pace_cnt;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pace_busy  <= 1'b0;
            pace_cnt   <= 9'h000;
            rev_wait_o <= 1'b0;
        end else if (ce_i) begin
            if (buf_loaded_i) begin
                pace_busy  <= 1'b1;
                pace_cnt   <= 9'h000;
                rev_wait_o <= 1'b0;
            end else if (host_drained_i && !rev_wait_o) begin
                pace_busy <= 1'b0;
            end else if (pace_busy && mark_rise) begin
                pace_cnt <= pace_cnt + 9'h001;
                if (!rev_wait_o && pace_cnt + 9'h001 == {1'b0, il}) begin
                    rev_wait_o <= 1'b1;
                    pace_cnt   <= 9'h000;
                end else if (rev_wait_o && pace_cnt + 9'h001 == {1'b0, sectors_per_track_i}) begin
                    rev_wait_o <= 1'b0;
                    pace_busy  <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // defect map sector parser
    logic [7:0]  dm_idx;
    logic [23:0] dm_stored;
    logic [7:0]  dm_count;
    logic [7:0]  dm_entry;
    logic [23:0] dm_track;
    logic        dm_final;
    logic [23:0] dm_hash;
    assign dm_entry = 8'((dm_idx - dcdm_pkg::MAP_FIRST_ENTRY) >> 2);

    dcdm_hash u_hash (
        .clk_sys_i    (clk_sys_i),
        .reset_i      (reset_i),
        .ce_i         (ce_i),
        .clear_i      (dm_start_i),
        .byte_valid_i (dm_valid_i && dm_idx >= dcdm_pkg::MAP_HASH_FIRST),
        .byte_i       (dm_byte_i),
        .hash_o       (dm_hash)
    );

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            dm_idx         <= 8'h00;
            dm_stored      <= 24'h000000;
            dm_count       <= 8'h00;
            dm_track       <= 24'h000000;
            dm_final       <= 1'b0;
            dm_done_o      <= 1'b0;
            dm_ok_o        <= 1'b0;
            defect_hit_o   <= 1'b0;
            defect_flags_o <= 3'h0;
        end else if (ce_i) begin
            dm_final  <= 1'b0;
            dm_done_o <= dm_final;
            if (dm_final) begin
                dm_ok_o <= (dm_hash == dm_stored) && (dm_count <= dcdm_pkg::MAP_MAX_ENTRIES);
            end
            if (dm_start_i) begin
                dm_idx       <= 8'h00;
                defect_hit_o <= 1'b0;
                dm_ok_o      <= 1'b0;
            end else if (dm_valid_i) begin
                dm_idx <= dm_idx + 8'h01;
                if (dm_idx < dcdm_pkg::MAP_COUNT_BYTE) begin
                    dm_stored[dm_idx[1:0]*8 +: 8] <= dm_byte_i;
                end else if (dm_idx == dcdm_pkg::MAP_COUNT_BYTE) begin
                    dm_count <= dm_byte_i;
                end else if (dm_idx[1:0] != 2'h3) begin
                    dm_track[(2 - dm_idx[1:0])*8 +: 8] <= dm_byte_i;
                end else if (dm_entry < dm_count && dm_track == linear_track_o && !on_map_cylinder_o) begin
                    defect_hit_o   <= 1'b1;
                    defect_flags_o <= {dm_byte_i[dcdm_pkg::FLAG_OS_BIT], dm_byte_i[dcdm_pkg::FLAG_DIAG_BIT],
                                       dm_byte_i[dcdm_pkg::FLAG_WHOLE_BIT]};
                end
                if (dm_idx == dcdm_pkg::MAP_LAST_BYTE) begin
                    dm_final <= 1'b1;
                end
            end
        end
    end

    // unreadable map sector: same sector number on the next copy track
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            copy_head_o <= 8'h00;
        end else if (ce_i) begin
            if (state == ST_EXEC) begin
                copy_head_o <= 8'h00;
            end else if (dm_read_fail_i) begin
                copy_head_o <= (copy_head_o + 8'h01 >= heads_per_cylinder_i) ? 8'h00 : copy_head_o + 8'h01;
            end
        end
    end

endmodule : dcdm_top

// >>> dv/dcdm_host_model.sv
// host model: hands six-byte commands to the block
`timescale 1ns/1ps
module dcdm_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic       cmd_ready_i,
    output logic            cmd_valid_o,
    output logic [7:0]      cmd_byte_o
);
    initial {cmd_valid_o, cmd_byte_o} = 9'h000;
    // ======
    // bytes go out in order, each held until taken
    task automatic send(input logic [47:0] c);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys_i);
            cmd_valid_o = 1'b1;
            cmd_byte_o = c[47 - 8 * i -: 8];
            do @(posedge clk_sys_i); while (cmd_ready_i !== 1'b1);
        end
        @(negedge clk_sys_i);
        cmd_valid_o = 1'b0;
        cmd_byte_o = ~cmd_byte_o; // released bus shows no stale byte
    endtask : send
endmodule : dcdm_host_model

// >>> dv/dcdm_checker_sva.sv
// checker on the decode block ports
`timescale 1ns/1ps
module dcdm_checker (
    input wire logic clk_sys_i, reset_i, done_o,
    input wire logic [7:0] status_byte_o, message_byte_o, opcode_o,
    input wire logic [7:0] heads_per_cylinder_i, sectors_per_track_i, head_index_i, sector_index_i,
    input wire logic [15:0] cylinder_index_i,
    input wire logic [31:0] logical_addr_o,
    input wire logic [23:0] linear_track_o,
    input wire dcdm_pkg::dcdm_group_e group_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // ======
    // address outputs lag their inputs by one cycle
    a_addr_math: assert property (!$past(reset_i) |-> logical_addr_o == ($past(cylinder_index_i)
        * heads_per_cylinder_i + $past(head_index_i)) * sectors_per_track_i + $past(sector_index_i)) else $error("addr");
    a_linear_track: assert property (!$past(reset_i) |->
        linear_track_o == $past(cylinder_index_i) * heads_per_cylinder_i + $past(head_index_i)) else $error("track");
    a_status_zeros: assert property (done_o |-> (status_byte_o & 8'h95) == 8'h00) else $error("status");
    a_error_msg: assert property (done_o |-> status_byte_o[1] == (message_byte_o != 8'h00)) else $error("msg");
    a_invalid_op: assert property (done_o && group_o == dcdm_pkg::GRP_INVALID |-> status_byte_o[1])
        else $error("invalid");
    a_ready_group: assert property (done_o && opcode_o == 8'h00 |-> group_o == dcdm_pkg::GRP_CONTROLLER)
        else $error("group");
    a_read_group: assert property (done_o && opcode_o inside {8'h08, 8'h09} |-> group_o == dcdm_pkg::GRP_RWS)
        else $error("group");
    a_done_pulse: assert property (done_o |=> !done_o [*2]) else $error("done");
    c_error: cover property (done_o && status_byte_o[1]);
    c_format: cover property (done_o && group_o == dcdm_pkg::GRP_TRACK);
    c_read: cover property (done_o && group_o == dcdm_pkg::GRP_RWS);
endmodule : dcdm_checker
bind dcdm_top dcdm_checker i_chk (.*);

// >>> dv/tb_dcdm_top.sv
// bench for the disk command decode block
`timescale 1ns/1ps
module tb_dcdm_top;
    logic clk_sys_i = 0, reset_i = 1, ce_i = 1, map_ready_i = 1, dm_start_i = 0, dm_valid_i = 0, buf_loaded_i = 0;
    logic sector_mark_i = 0, host_drained_i = 0, dm_read_fail_i = 0, cmd_valid_i, cmd_ready_o, done_o, map_valid_o;
    logic on_map_cylinder_o, rev_wait_o, dm_done_o, dm_ok_o, defect_hit_o;
    logic [7:0] cmd_byte_i, status_byte_o, message_byte_o, opcode_o, map_logical_o, map_physical_o, copy_head_o;
    logic [7:0] heads_per_cylinder_i = 8'h04, sectors_per_track_i = 8'h20, head_index_i = 8'h03, sector_index_i = 8'h1F;
    logic [7:0] dm_byte_i = 8'h00;
    logic [15:0] cylinders_i = 16'h0064, cylinder_index_i = 16'h0062;
    logic [31:0] logical_addr_o;
    logic [23:0] linear_track_o;
    logic [2:0] unit_ready_i = 3'h7, defect_flags_o;
    logic [1:0] write_protect_i = 2'h0;
    dcdm_pkg::dcdm_group_e group_o, g;
    int n_errors = 0, n_checks = 0;
    dcdm_top i_dut (.*);
    dcdm_host_model i_host (.clk_sys_i, .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    // ======
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        finish_test();
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic run_cmd(input logic [47:0] c);
        int k = 0;
        i_host.send(c);
        do begin @(negedge clk_sys_i); k++; end while (done_o !== 1'b1 && k < 99);
        check("done", done_o, 1);
    endtask : run_cmd
    task automatic t_decode;
        for (int op = 0; op < 22; op++) begin
            case (op)
                0, 3, 12, 17: g = dcdm_pkg::GRP_CONTROLLER;
                1, 4, 5, 6, 7, 14: g = op < 5 ? dcdm_pkg::GRP_DISK : dcdm_pkg::GRP_TRACK;
                15, 16: g = dcdm_pkg::GRP_BUFFER;
                2, 21: g = dcdm_pkg::GRP_INVALID;
                default: g = dcdm_pkg::GRP_RWS;
            endcase
            run_cmd({8'(op), 24'h000000, 8'h05, 8'h00});
            check("group", group_o, g);
            check("status", status_byte_o, g == dcdm_pkg::GRP_INVALID ? 8'h02 : 8'h00);
        end
    endtask : t_decode
    task automatic t_ready;
        unit_ready_i = 3'h5;
        write_protect_i = 2'h2;
        run_cmd(48'h0020_0000_0000);
        check("status", status_byte_o, 8'h2A);
        check("message", message_byte_o, 8'h84);
    endtask : t_ready
    task automatic t_map;
        map_ready_i = 1'b0;
        i_host.send(48'h0600_0000_0500);
        repeat (40) @(negedge clk_sys_i);
        map_ready_i = 1'b1;
        for (int n = 0; n < 32; n++) begin
            check("map", {map_valid_o, map_logical_o, map_physical_o}, {1'b1, 8'(n), 8'(n * 5 % 32)});
            @(negedge clk_sys_i);
        end
    endtask : t_map
    task automatic t_pace;
        buf_loaded_i = 1'b1;
        for (int m = 0; m < 5; m++) begin
            repeat (2) @(negedge clk_sys_i) {buf_loaded_i, sector_mark_i} = {1'b0, ~sector_mark_i};
            repeat (2) @(negedge clk_sys_i);
            check("rev wait", rev_wait_o, m == 4);
        end
    endtask : t_pace
    task automatic t_defect;
        logic [7:0] b [256] = '{default: 8'h00};
        logic [23:0] h = dcdm_pkg::HASH_INIT;
        cylinder_index_i = 16'h0061;
        {b[3], b[4], b[5], b[6], b[7]} = 40'h01_000187_05;
        for (int i = 3; i < 256; i++) h = {h[22:0], h[23]} ^ {16'h0000, b[i]};
        {b[2], b[1], b[0]} = h;
        dm_start_i = 1'b1;
        foreach (b[i]) @(negedge clk_sys_i) {dm_start_i, dm_valid_i, dm_byte_i} = {1'b0, 1'b1, b[i]};
        @(negedge clk_sys_i) {dm_valid_i, dm_read_fail_i} = 2'h1;
        @(negedge clk_sys_i) dm_read_fail_i = 1'b0;
        check("map sector", {dm_done_o, dm_ok_o, defect_hit_o, defect_flags_o}, 6'h3D);
        check("copy head", copy_head_o, 8'h01);
    endtask : t_defect
    initial begin
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        @(negedge clk_sys_i);
        check("map cylinder", on_map_cylinder_o, 1);
        t_decode();
        t_ready();
        t_map();
        t_pace();
        t_defect();
        finish_test();
    end
endmodule : tb_dcdm_top
